// ### core/tlic_pkg.sv
// Purpose: shared constants for the two-level interrupt controller
// Assumes: 8-bit special-function register port from the core
// Notes: source indices follow the fixed polling order, index 0 polled first
package tlic_pkg;
   localparam logic [7:0] ADDR_ENABLE_MAIN = 8'h_a8;
   localparam logic [7:0] ADDR_ENABLE_LEVEL_AUX = 8'h_a9;
   localparam logic [7:0] ADDR_LEVEL_MAIN = 8'h_b8;
   localparam logic [7:0] RESET_ENABLE_MAIN = 8'h_00;
   localparam logic [7:0] RESET_ENABLE_LEVEL_AUX = 8'h_a0;
   localparam logic [7:0] RESET_LEVEL_MAIN = 8'h_00;
   // field positions in the main enable and level registers
   localparam int BIT_GLOBAL_GATE = 7;
   localparam int BIT_CONVERTER = 6;
   localparam int BIT_TIMER_TWO = 5;
   localparam int BIT_UART = 4;
   localparam int BIT_TIMER_ONE = 3;
   localparam int BIT_EXT_ONE = 2;
   localparam int BIT_TIMER_ZERO = 1;
   localparam int BIT_EXT_ZERO = 0;
   // field positions in the auxiliary register
   localparam int BIT_INTERVAL_LEVEL = 6;
   localparam int BIT_SUPPLY_LEVEL = 5;
   localparam int BIT_SERIAL_LEVEL = 4;
   localparam int BIT_AUX_RESERVED = 3;
   localparam int BIT_INTERVAL_EN = 2;
   localparam int BIT_SUPPLY_EN = 1;
   localparam int BIT_SERIAL_EN = 0;
   localparam logic [7:0] MASK_LEVEL_MAIN = 8'h_7f;
   localparam logic [7:0] MASK_AUX_WRITE = 8'h_77;
   localparam int NUM_SOURCES = 11;
   // polling order indices
   localparam int SRC_SUPPLY = 0;
   localparam int SRC_WATCHDOG = 1;
   localparam int SRC_EXT_ZERO = 2;
   localparam int SRC_CONVERTER = 3;
   localparam int SRC_TIMER_ZERO = 4;
   localparam int SRC_EXT_ONE = 5;
   localparam int SRC_TIMER_ONE = 6;
   localparam int SRC_SERIAL = 7;
   localparam int SRC_UART = 8;
   localparam int SRC_TIMER_TWO = 9;
   localparam int SRC_INTERVAL = 10;
   localparam logic [15:0] VEC_EXT_ZERO = 16'h_0003;
   localparam logic [15:0] VEC_TIMER_ZERO = 16'h_000b;
   localparam logic [15:0] VEC_EXT_ONE = 16'h_0013;
   localparam logic [15:0] VEC_TIMER_ONE = 16'h_001b;
   localparam logic [15:0] VEC_UART = 16'h_0023;
   localparam logic [15:0] VEC_TIMER_TWO = 16'h_002b;
   localparam logic [15:0] VEC_CONVERTER = 16'h_0033;
   localparam logic [15:0] VEC_SERIAL = 16'h_003b;
   localparam logic [15:0] VEC_SUPPLY = 16'h_0043;
   localparam logic [15:0] VEC_INTERVAL = 16'h_0053;
   localparam logic [15:0] VEC_WATCHDOG = 16'h_005b;
   typedef enum logic [1:0] {
      TLIC_IDLE = 2'b00,
      TLIC_PUSH = 2'b01,
      TLIC_LOAD = 2'b10
   } tlic_state_t;
endpackage

// ### core/tlic_level_arbiter.sv
// Purpose: fixed-order pick among requests of one level
// Assumes: bit 0 is polled first
// Notes: one instance per level
`timescale 1ns/1ps
module tlic_level_arbiter #(
   parameter int N = 11
) (
   input wire logic [N-1:0] req,
   output logic hit,
   output logic [3:0] index
);
   always_comb begin
      hit = 1'b0;
      index = 4'h_0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            hit = 1'b1;
            index = 4'(i);
         end
      end
   end
endmodule

// ### core/tlic_controller.sv
// Purpose: two-level interrupt controller with fixed vectors
// Assumes: core pushes the pc on push_pc, loads vector on load_vector, pulses reti
// Notes: requests are levels held by the sources until serviced
`timescale 1ns/1ps
// Summary of operation
// RULE1: eleven sources, each pending request sorted into high or low level
// RULE2: main enable bit 7 gates all maskable sources
// RULE3: main enable resets to zero; bits 6..0 enable seven sources
// RULE4: main level register resets to zero; bits 6..0 pick high or low
// RULE5: aux register resets to a0h; bits 6..4 levels, bits 2..0 enables
// RULE6: software writes zero into aux bit 3
// RULE7: high-level request preempts a running low-level service
// RULE8: simultaneous requests of both levels: high level goes first
// RULE9: no new request of a level already in service
// RULE10: equal level ties broken by fixed polling order
// RULE11: on acceptance pc is pushed, then the vector is loaded
// RULE12: each source has a fixed vector address
// RULE13: watchdog in interrupt mode requests on timeout instead of reset
// RULE14: watchdog request is always high level
// RULE15: global gate never blocks the watchdog request
// RULE16: watchdog requests only with a nonzero timeout setting
// RULE17: one in-service flag per level, set on vector, cleared by return
module tlic_controller #(
   parameter int TIMEOUT_W = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_write,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic supply_monitor_request,
   input wire logic watchdog_timeout_request,
   input wire logic ext_zero_request,
   input wire logic converter_ready_request,
   input wire logic timer_zero_overflow,
   input wire logic ext_one_request,
   input wire logic timer_one_overflow,
   input wire logic sync_serial_request,
   input wire logic uart_rx_tx_request,
   input wire logic timer_two_request,
   input wire logic interval_counter_request,
   input wire logic watchdog_irq_mode,
   input wire logic [TIMEOUT_W-1:0] watchdog_timeout_sel,
   input wire logic core_ready,
   input wire logic reti,
   output logic irq_pending,
   output logic push_pc,
   output logic load_vector,
   output logic [15:0] vector_addr,
   output logic [3:0] taken_source,
   output logic watchdog_reset,
   output logic [1:0] in_service
);
   logic [7:0] irq_enable_main;
   logic [7:0] irq_enable_level_aux;
   logic [7:0] irq_level_main;
   logic [10:0] raw_req;
   logic [10:0] enabled;
   logic [10:0] level_high;
   logic [10:0] req_hi;
   logic [10:0] req_lo;
   logic hit_hi;
   logic hit_lo;
   logic [3:0] idx_hi;
   logic [3:0] idx_lo;
   logic accept;
   logic accept_high;
   logic [3:0] accept_idx;
   logic wd_event;
   logic service_high;
   logic service_low;
   tlic_pkg::tlic_state_t state;
   logic pending_high;
   logic [15:0] next_vector;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_main <= tlic_pkg::RESET_ENABLE_MAIN; // see RULE3
      end else if (sfr_write && sfr_addr == tlic_pkg::ADDR_ENABLE_MAIN) begin
         irq_enable_main <= sfr_wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_level_main <= tlic_pkg::RESET_LEVEL_MAIN; // see RULE4
      end else if (sfr_write && sfr_addr == tlic_pkg::ADDR_LEVEL_MAIN) begin
         irq_level_main <= sfr_wdata & tlic_pkg::MASK_LEVEL_MAIN;
      end
   end

   // bits 7 and 3 keep their reset value; bit 3 is never stored as one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_level_aux <= tlic_pkg::RESET_ENABLE_LEVEL_AUX; // see RULE5
      end else if (sfr_write && sfr_addr == tlic_pkg::ADDR_ENABLE_LEVEL_AUX) begin
         irq_enable_level_aux <= (sfr_wdata & tlic_pkg::MASK_AUX_WRITE)
            | (tlic_pkg::RESET_ENABLE_LEVEL_AUX & ~tlic_pkg::MASK_AUX_WRITE); // see RULE6
      end
   end

   always_comb begin
      sfr_hit = 1'b1;
      case (sfr_addr)
         tlic_pkg::ADDR_ENABLE_MAIN: sfr_rdata = irq_enable_main;
         tlic_pkg::ADDR_ENABLE_LEVEL_AUX: sfr_rdata = irq_enable_level_aux;
         tlic_pkg::ADDR_LEVEL_MAIN: sfr_rdata = irq_level_main;
         default: begin
            sfr_rdata = 8'h_00;
            sfr_hit = 1'b0;
         end
      endcase
   end

   // watchdog interrupt needs the mode bit and a nonzero timeout
   assign wd_event = watchdog_timeout_request && watchdog_irq_mode
      && (watchdog_timeout_sel != '0); // see RULE13 see RULE16
   assign watchdog_reset = watchdog_timeout_request && !watchdog_irq_mode; // see RULE13

   always_comb begin
      raw_req = '0;
      raw_req[tlic_pkg::SRC_SUPPLY] = supply_monitor_request;
      raw_req[tlic_pkg::SRC_WATCHDOG] = wd_event;
      raw_req[tlic_pkg::SRC_EXT_ZERO] = ext_zero_request;
      raw_req[tlic_pkg::SRC_CONVERTER] = converter_ready_request;
      raw_req[tlic_pkg::SRC_TIMER_ZERO] = timer_zero_overflow;
      raw_req[tlic_pkg::SRC_EXT_ONE] = ext_one_request;
      raw_req[tlic_pkg::SRC_TIMER_ONE] = timer_one_overflow;
      raw_req[tlic_pkg::SRC_SERIAL] = sync_serial_request;
      raw_req[tlic_pkg::SRC_UART] = uart_rx_tx_request;
      raw_req[tlic_pkg::SRC_TIMER_TWO] = timer_two_request;
      raw_req[tlic_pkg::SRC_INTERVAL] = interval_counter_request;
   end

   // global gate folds into every maskable enable; watchdog bypasses it
   always_comb begin
      enabled = '0;
      level_high = '0;
      enabled[tlic_pkg::SRC_SUPPLY] = irq_enable_level_aux[tlic_pkg::BIT_SUPPLY_EN];
      enabled[tlic_pkg::SRC_EXT_ZERO] = irq_enable_main[tlic_pkg::BIT_EXT_ZERO];
      enabled[tlic_pkg::SRC_CONVERTER] = irq_enable_main[tlic_pkg::BIT_CONVERTER];
      enabled[tlic_pkg::SRC_TIMER_ZERO] = irq_enable_main[tlic_pkg::BIT_TIMER_ZERO];
      enabled[tlic_pkg::SRC_EXT_ONE] = irq_enable_main[tlic_pkg::BIT_EXT_ONE];
      enabled[tlic_pkg::SRC_TIMER_ONE] = irq_enable_main[tlic_pkg::BIT_TIMER_ONE];
      enabled[tlic_pkg::SRC_SERIAL] = irq_enable_level_aux[tlic_pkg::BIT_SERIAL_EN];
      enabled[tlic_pkg::SRC_UART] = irq_enable_main[tlic_pkg::BIT_UART];
      enabled[tlic_pkg::SRC_TIMER_TWO] = irq_enable_main[tlic_pkg::BIT_TIMER_TWO];
      enabled[tlic_pkg::SRC_INTERVAL] = irq_enable_level_aux[tlic_pkg::BIT_INTERVAL_EN];
      enabled = enabled & {11{irq_enable_main[tlic_pkg::BIT_GLOBAL_GATE]}}; // see RULE2
      enabled[tlic_pkg::SRC_WATCHDOG] = 1'b1; // see RULE15
      level_high[tlic_pkg::SRC_SUPPLY] = irq_enable_level_aux[tlic_pkg::BIT_SUPPLY_LEVEL];
      level_high[tlic_pkg::SRC_WATCHDOG] = 1'b1; // see RULE14
      level_high[tlic_pkg::SRC_EXT_ZERO] = irq_level_main[tlic_pkg::BIT_EXT_ZERO];
      level_high[tlic_pkg::SRC_CONVERTER] = irq_level_main[tlic_pkg::BIT_CONVERTER];
      level_high[tlic_pkg::SRC_TIMER_ZERO] = irq_level_main[tlic_pkg::BIT_TIMER_ZERO];
      level_high[tlic_pkg::SRC_EXT_ONE] = irq_level_main[tlic_pkg::BIT_EXT_ONE];
      level_high[tlic_pkg::SRC_TIMER_ONE] = irq_level_main[tlic_pkg::BIT_TIMER_ONE];
      level_high[tlic_pkg::SRC_SERIAL] = irq_enable_level_aux[tlic_pkg::BIT_SERIAL_LEVEL];
      level_high[tlic_pkg::SRC_UART] = irq_level_main[tlic_pkg::BIT_UART];
      level_high[tlic_pkg::SRC_TIMER_TWO] = irq_level_main[tlic_pkg::BIT_TIMER_TWO];
      level_high[tlic_pkg::SRC_INTERVAL] = irq_enable_level_aux[tlic_pkg::BIT_INTERVAL_LEVEL];
   end

   assign req_hi = raw_req & enabled & level_high; // see RULE1
   assign req_lo = raw_req & enabled & ~level_high; // see RULE1

   tlic_level_arbiter #(.N(tlic_pkg::NUM_SOURCES)) u_arb_hi (
      .req(req_hi),
      .hit(hit_hi),
      .index(idx_hi)
   );

   tlic_level_arbiter #(.N(tlic_pkg::NUM_SOURCES)) u_arb_lo (
      .req(req_lo),
      .hit(hit_lo),
      .index(idx_lo)
   );

   // high runs over low service; low waits for any service to end
   always_comb begin
      accept_high = hit_hi && !service_high; // see RULE7 see RULE9
      accept = accept_high || (hit_lo && !service_high && !service_low); // see RULE9
      accept_idx = accept_high ? idx_hi : idx_lo; // see RULE8 see RULE10
   end

   assign irq_pending = accept && state == tlic_pkg::TLIC_IDLE;

   always_comb begin
      case (accept_idx)
         4'(tlic_pkg::SRC_SUPPLY): next_vector = tlic_pkg::VEC_SUPPLY; // see RULE12
         4'(tlic_pkg::SRC_WATCHDOG): next_vector = tlic_pkg::VEC_WATCHDOG;
         4'(tlic_pkg::SRC_EXT_ZERO): next_vector = tlic_pkg::VEC_EXT_ZERO;
         4'(tlic_pkg::SRC_CONVERTER): next_vector = tlic_pkg::VEC_CONVERTER;
         4'(tlic_pkg::SRC_TIMER_ZERO): next_vector = tlic_pkg::VEC_TIMER_ZERO;
         4'(tlic_pkg::SRC_EXT_ONE): next_vector = tlic_pkg::VEC_EXT_ONE;
         4'(tlic_pkg::SRC_TIMER_ONE): next_vector = tlic_pkg::VEC_TIMER_ONE;
         4'(tlic_pkg::SRC_SERIAL): next_vector = tlic_pkg::VEC_SERIAL;
         4'(tlic_pkg::SRC_UART): next_vector = tlic_pkg::VEC_UART;
         4'(tlic_pkg::SRC_TIMER_TWO): next_vector = tlic_pkg::VEC_TIMER_TWO;
         4'(tlic_pkg::SRC_INTERVAL): next_vector = tlic_pkg::VEC_INTERVAL;
         default: next_vector = 16'h_0000;
      endcase
   end

   // choice is frozen at acceptance so a late request cannot swap the vector
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= tlic_pkg::TLIC_IDLE;
         vector_addr <= 16'h_0000;
         taken_source <= 4'h_0;
         pending_high <= 1'b0;
      end else begin
         case (state)
            tlic_pkg::TLIC_IDLE: begin
               if (accept && core_ready) begin
                  state <= tlic_pkg::TLIC_PUSH;
                  vector_addr <= next_vector;
                  taken_source <= accept_idx;
                  pending_high <= accept_high;
               end
            end
            tlic_pkg::TLIC_PUSH: state <= tlic_pkg::TLIC_LOAD; // see RULE11
            tlic_pkg::TLIC_LOAD: state <= tlic_pkg::TLIC_IDLE;
            default: state <= tlic_pkg::TLIC_IDLE;
         endcase
      end
   end

   assign push_pc = state == tlic_pkg::TLIC_PUSH; // see RULE11
   assign load_vector = state == tlic_pkg::TLIC_LOAD; // see RULE11

   // return ends the most important active level first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         service_high <= 1'b0;
         service_low <= 1'b0;
      end else begin
         if (load_vector && pending_high) begin
            service_high <= 1'b1; // see RULE17
         end else if (reti && service_high) begin
            service_high <= 1'b0; // see RULE17
         end
         if (load_vector && !pending_high) begin
            service_low <= 1'b1; // see RULE17
         end else if (reti && !service_high) begin
            service_low <= 1'b0;
         end
      end
   end

   assign in_service = {service_high, service_low};
endmodule

// ### sim/tlic_checker_sva.sv
// Purpose: concurrent checks on the controller ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: vector table kept here apart from the design
`timescale 1ns/1ps
module tlic_checker #(
   parameter int TIMEOUT_W = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic watchdog_timeout_request,
   input wire logic watchdog_irq_mode,
   input wire logic [TIMEOUT_W-1:0] watchdog_timeout_sel,
   input wire logic core_ready,
   input wire logic reti,
   input wire logic irq_pending,
   input wire logic push_pc,
   input wire logic load_vector,
   input wire logic [15:0] vector_addr,
   input wire logic [3:0] taken_source,
   input wire logic watchdog_reset,
   input wire logic [1:0] in_service
);
   localparam logic [15:0] VT [0:10] = '{16'h_0043, 16'h_005b, 16'h_0003, 16'h_0033,
      16'h_000b, 16'h_0013, 16'h_001b, 16'h_003b, 16'h_0023, 16'h_002b, 16'h_0053};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_push_load; push_pc |=> load_vector && !push_pc; endproperty
   a_push_load: assert property (p_push_load) else $error("no load after push");
   property p_load_src; load_vector |-> $past(push_pc) && !push_pc; endproperty
   a_load_src: assert property (p_load_src) else $error("load without push");
   property p_accept; irq_pending && core_ready |=> push_pc; endproperty
   a_accept: assert property (p_accept) else $error("request not taken");
   property p_vector; push_pc |-> vector_addr == VT[taken_source]; endproperty
   a_vector: assert property (p_vector) else $error("wrong vector");
   property p_svc_set; push_pc |=> ##1 (in_service != $past(in_service, 2)); endproperty
   a_svc_set: assert property (p_svc_set) else $error("service flag not set");
   property p_high_block; in_service[1] |-> !irq_pending; endproperty
   a_high_block: assert property (p_high_block) else $error("taken during high");
   property p_ret_high; reti && in_service[1] |=> !in_service[1]; endproperty
   a_ret_high: assert property (p_ret_high) else $error("high flag kept");
   property p_ret_low; reti && in_service == 2'h_1 |=> in_service == 2'h_0; endproperty
   a_ret_low: assert property (p_ret_low) else $error("low flag kept");
   property p_wd_mode;
      watchdog_timeout_request || watchdog_irq_mode |-> watchdog_reset == !watchdog_irq_mode;
   endproperty
   a_wd_mode: assert property (p_wd_mode) else $error("watchdog mode wrong");
   property p_wd_zero; push_pc && $past(watchdog_timeout_sel) == '0 |-> taken_source != 4'h_1;
   endproperty
   a_wd_zero: assert property (p_wd_zero) else $error("watchdog with zero");
   property p_unmapped; !sfr_hit |-> sfr_rdata == 8'h_00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   c_push: cover property (push_pc);
   c_nest: cover property (in_service == 2'h_3);
   c_wd: cover property (push_pc && taken_source == 4'h_1);
endmodule

// ### sim/tlic_core_model.sv
// Purpose: behavioural core that pushes, vectors and returns
// Assumes: ret_req is a one-cycle pulse from the bench
// Notes: four-deep stack, enough for two nested levels
`timescale 1ns/1ps
module tlic_core_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic push_pc,
   input wire logic load_vector,
   input wire logic [15:0] vector_addr,
   input wire logic ret_req,
   output logic core_ready,
   output logic reti,
   output logic [15:0] pc
);
   logic [15:0] stack [0:3];
   logic [1:0] depth;
   // no instruction boundary while vectoring
   assign core_ready = rst_n && !push_pc && !load_vector;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pc <= 16'h_0100;
         depth <= 2'h_0;
         reti <= 1'b0;
      end else begin
         reti <= ret_req;
         if (push_pc) begin
            stack[depth] <= pc;
            depth <= depth + 2'h_1;
         end else if (load_vector) begin
            pc <= vector_addr;
         end else if (reti) begin
            pc <= stack[depth - 2'h_1];
            depth <= depth - 2'h_1;
         end
      end
   end
endmodule

// ### sim/testbench.sv
// Purpose: directed bench for the two-level interrupt controller
// Assumes: core model answers pushes and returns
// Notes: req is indexed by polling order
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic rst_n, sfr_write, ret_req, core_ready, reti, wd_mode;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [10:0] req;
   logic [3:0] wd_sel, taken_source;
   logic [15:0] vector_addr, pc;
   logic [1:0] in_service;
   logic sfr_hit, irq_pending, push_pc, load_vector, watchdog_reset;
   int mismatches = 0;
   int check_count = 0;
   localparam logic [15:0] VT [0:10] = '{16'h_0043, 16'h_005b, 16'h_0003, 16'h_0033,
      16'h_000b, 16'h_0013, 16'h_001b, 16'h_003b, 16'h_0023, 16'h_002b, 16'h_0053};
   tlic_controller dut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_write(sfr_write), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .supply_monitor_request(req[0]), .watchdog_timeout_request(req[1]),
      .ext_zero_request(req[2]), .converter_ready_request(req[3]), .timer_zero_overflow(req[4]),
      .ext_one_request(req[5]), .timer_one_overflow(req[6]), .sync_serial_request(req[7]),
      .uart_rx_tx_request(req[8]), .timer_two_request(req[9]), .interval_counter_request(req[10]),
      .watchdog_irq_mode(wd_mode), .watchdog_timeout_sel(wd_sel), .core_ready(core_ready),
      .reti(reti), .irq_pending(irq_pending), .push_pc(push_pc), .load_vector(load_vector),
      .vector_addr(vector_addr), .taken_source(taken_source), .watchdog_reset(watchdog_reset),
      .in_service(in_service));
   tlic_core_model core (.clock(clock), .rst_n(rst_n), .push_pc(push_pc),
      .load_vector(load_vector), .vector_addr(vector_addr), .ret_req(ret_req),
      .core_ready(core_ready), .reti(reti), .pc(pc));
   always #20 clock = ~clock;
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_write = 1'b1;
      tick(1);
      sfr_write = 1'b0;
      // one idle edge so back-to-back writes never retoggle the strobe in one step
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      tick(1);
      chk({8'h_00, sfr_rdata}, {8'h_00, e});
   endtask
   task automatic take(input int s);
      for (int k = 0; k < 20 && push_pc !== 1'b1; k++) tick(1);
      chk({15'h_0, push_pc}, 16'h_0001);
      chk({12'h_000, taken_source}, 16'(s));
      chk(vector_addr, VT[s]);
   endtask
   task automatic ret();
      tick(2);
      ret_req = 1'b1;
      tick(1);
      ret_req = 1'b0;
   endtask
   task automatic t_regs();
      rd(8'h_a8, 8'h_00);
      rd(8'h_a9, 8'h_a0);
      rd(8'h_b8, 8'h_00);
      rd(8'h_c0, 8'h_00);
      chk({15'h_0, sfr_hit}, 16'h_0000);
      wr(8'h_a9, 8'h_77);
      rd(8'h_a9, 8'h_f7);
      wr(8'h_b8, 8'h_ff);
      rd(8'h_b8, 8'h_7f);
      wr(8'h_a8, 8'h_a5);
      rd(8'h_a8, 8'h_a5);
      wr(8'h_b8, 8'h_00);
   endtask
   task automatic t_gate();
      wr(8'h_a8, 8'h_01);
      req[2] = 1'b1;
      tick(3);
      chk({15'h_0, irq_pending}, 16'h_0000);
      wr(8'h_a8, 8'h_81);
      take(2);
      tick(2);
      chk(pc, VT[2]);
      req[2] = 1'b0;
      ret();
   endtask
   task automatic t_order();
      wr(8'h_a8, 8'h_ff);
      wr(8'h_a9, 8'h_07);
      req = 11'h_7fd;
      for (int i = 0; i < 11; i++) begin
         if (i != 1) begin
            take(i);
            req[i] = 1'b0;
            ret();
         end
      end
   endtask
   task automatic t_preempt();
      wr(8'h_b8, 8'h_0c);
      wr(8'h_a8, 8'h_8d);
      req[2] = 1'b1;
      take(2);
      tick(2);
      chk({14'h_0, in_service}, 16'h_0001);
      req[6] = 1'b1;
      take(6);
      req[5] = 1'b1;
      tick(3);
      chk({14'h_0, in_service}, 16'h_0003);
      chk({15'h_0, irq_pending}, 16'h_0000);
      req[6] = 1'b0;
      req[2] = 1'b0;
      ret();
      take(5);
      req[5] = 1'b0;
      ret();
      ret();
      tick(2);
      chk({14'h_0, in_service}, 16'h_0000);
   endtask
   task automatic t_simul();
      wr(8'h_b8, 8'h_00);
      wr(8'h_a9, 8'h_44);
      wr(8'h_a8, 8'h_81);
      req[2] = 1'b1;
      req[10] = 1'b1;
      take(10);
      req[10] = 1'b0;
      ret();
      take(2);
      req[2] = 1'b0;
      ret();
   endtask
   task automatic t_watchdog();
      wr(8'h_a8, 8'h_00);
      wd_mode = 1'b1;
      wd_sel = 4'h_3;
      req[1] = 1'b1;
      take(1);
      tick(2);
      chk({14'h_0, in_service}, 16'h_0002);
      req[1] = 1'b0;
      ret();
      wd_sel = 4'h_0;
      req[1] = 1'b1;
      tick(3);
      chk({15'h_0, irq_pending}, 16'h_0000);
      chk({15'h_0, watchdog_reset}, 16'h_0000);
      wd_mode = 1'b0;
      tick(1);
      chk({15'h_0, watchdog_reset}, 16'h_0001);
      req[1] = 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      {sfr_write, ret_req, wd_mode} = 3'h_0;
      sfr_addr = 8'h_00;
      sfr_wdata = 8'h_00;
      req = 11'h_000;
      wd_sel = 4'h_0;
      repeat (20) @(posedge clock);
      #1;
      rst_n = 1'b1;
      t_regs();
      t_gate();
      t_order();
      t_preempt();
      t_simul();
      t_watchdog();
      close_out();
   end
   // about 150 cycles expected; 5000-cycle limit, far margin
   initial begin
      #200000;
      mismatches++;
      close_out();
   end
endmodule
bind tlic_controller tlic_checker #(.TIMEOUT_W(TIMEOUT_W)) u_chk (.clock(clock), .rst_n(rst_n),
   .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .watchdog_timeout_request(watchdog_timeout_request),
   .watchdog_irq_mode(watchdog_irq_mode), .watchdog_timeout_sel(watchdog_timeout_sel),
   .core_ready(core_ready), .reti(reti), .irq_pending(irq_pending), .push_pc(push_pc),
   .load_vector(load_vector), .vector_addr(vector_addr), .taken_source(taken_source),
   .watchdog_reset(watchdog_reset), .in_service(in_service));
